// File: logic/twm_pkg.sv
// Register map, field layout and engine types of the two-wire master.
package twm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FLG_W  = 9;

  // ======================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CONTROL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE      = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_INT_ADDR  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_WAV = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_INT_EN    = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_INT_DIS   = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK  = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_RX_HOLD   = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_TX_HOLD   = 8'h34;

  // ======================================================================
  // Field positions and widths
  localparam int CTL_START = 0;
  localparam int CTL_STOP  = 1;
  localparam int CTL_MASTER_ENABLE_CMD  = 2;
  localparam int CTL_MSDIS = 3;
  localparam int CTL_SWRST = 7;
  localparam int MODE_IASZ_LSB = 8;
  localparam int MODE_READ_BIT = 12;
  localparam int MODE_TARGET_DEVICE_ADDRESS_LSB = 16;
  localparam int TARGET_DEVICE_ADDRESS_W  = 7;
  localparam int INTERNAL_ADDR_VALUE_W  = 24;
  localparam int CWG_LOW_LSB  = 0;
  localparam int CWG_HIGH_LSB = 8;
  localparam int CWG_EXP_LSB  = 16;
  localparam int DIV_W   = 8;
  localparam int EXP_W   = 3;
  localparam int BYTE_W  = 8;
  localparam logic [3:0] ACK_BIT  = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // ======================================================================
  // Status flag positions and reset values
  localparam int FLG_TRANSFER_COMPLETE = 0;
  localparam int FLG_RX_BYTE_READY  = 1;
  localparam int FLG_TX_HOLDING_EMPTY  = 2;
  localparam int FLG_OVERRUN_FLAG   = 6;
  localparam int FLG_UNDERRUN_FLAG   = 7;
  localparam int FLG_NO_ACK_FLAG   = 8;
  localparam logic [FLG_W-1:0] FLAG_RESET = 9'h005;
  localparam logic [FLG_W-1:0] FLAG_USED  = 9'h1c7;
  localparam int PHASE_EXTRA = 3;

  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_LO, ST_HI, ST_STOP_LO, ST_STOP_HI, ST_STOP_END,
    ST_RS_LO, ST_RS_HI
  } twm_state_type;
  typedef enum logic [1:0] {STG_DEV, STG_INTERNAL_ADDR_VALUE, STG_RDEV, STG_DATA}
    twm_stage_type;
  typedef enum logic [2:0] {N_INTERNAL_ADDR_VALUE, N_RS, N_RX, N_TX} twm_next_type;
endpackage : twm_pkg

// File: logic/twm_master.sv
// Two-wire serial master with register port, clock generator and flags.
//
// Functional notes
// - Address size field 9:8 sends zero to three internal address bytes.
// - Direction bit 12: 0 write, 1 read; sent after slave address.
// - Programmed target address selects the slave on reads and writes.
// - Internal address register supplies the internal bytes, low byte last.
// - Clock low phase is low divisor times 2^exponent plus 3 cycles.
// - Clock high phase is high divisor times 2^exponent plus 3 cycles.
// - Exponent scales both phases by the same power of two.
// - Complete flag is 0 during a frame; set after stop or enable.
// - Receive-ready flag set when a byte lands in receive holding.
// - Transmit-empty cleared by holding write; set on load, enable, no_ack_flag.
// - Overrun set on a received byte while receive-ready; status read clears it only while complete flag is set.
// - Underrun set when shifter finds holding empty and no stop is requested; stop sent automatically.
// - No-ack flag set with complete flag; status read clears it.
// - Writing 1 to interrupt-enable sets that enable; 0 leaves it.
// - Writing 1 to interrupt-disable clears that enable; 0 leaves it.
// - Mask register reads enabled interrupts at status bit positions.
// - Receive holding register shows last received byte in bits 7:0.
// - After start, seven address bits then direction bit are sent.
// - Reading receive holding clears receive-ready.
`timescale 1ns/10ps
module twm_master #(
  parameter int CNT_W = 16
) (
  input  wire logic                       clk_in,
  input  wire logic                       reset_n_in,
  input  wire logic [twm_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [twm_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic      [twm_pkg::DATA_W-1:0] rdata_out,
  input  wire logic                       scl_in,
  output logic                            scl_out,
  output logic                            scl_oe_out,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe_out,
  output logic                            irq_out
);
  import twm_pkg::*;

  if (CNT_W < DIV_W + (1 << EXP_W)) begin : g_cnt_check
    $error("CNT_W too narrow for the largest clock phase");
  end

  // ======================================================================
  // Registers and state
  logic [TARGET_DEVICE_ADDRESS_W-1:0] target_device_address_q;
  logic              mode_rd_q;
  logic [1:0]        iasz_q;
  logic [INTERNAL_ADDR_VALUE_W-1:0] internal_addr_value_q;
  logic [DIV_W-1:0]  low_phase_divisor_q, high_phase_divisor_q;
  logic [EXP_W-1:0]  divisor_exponent_q;
  logic [BYTE_W-1:0] thr_q, rhr_q, sh_q;
  logic [FLG_W-1:0]  flags_q, imask_q, flag_set, flag_clr;
  logic              master_enable_cmd_q, start_req_q, stop_req_q;
  logic [DATA_W-1:0] rdata_q;
  logic              irq_q;
  twm_state_type     state_q;
  twm_stage_type     stage_q;
  twm_next_type      nxt;
  logic [CNT_W-1:0]  tmr_q, lo_run_q, hi_run_q;
  logic [3:0]        bit_q;
  logic [1:0]        idx_q, fsz_q;
  logic              txm_q, last_q, no_ack_flag_pend_q, frd_q;
  logic              ev_begin_q, ev_done_q, ev_rx_q, ev_load_q;
  logic              ev_no_ack_flag_q, ev_underrun_flag_q, ev_stop_q;
  logic              scl_m_q, scl_s_q, sda_m_q, sda_s_q;
  logic              scl_drv_q, sda_pre_q, sda_drv_q;
  logic              scl_want, sda_want;

  // ======================================================================
  // Register decode
  wire wr_ctl  = wr_in && addr_in == OFF_CONTROL;
  wire wr_mode = wr_in && addr_in == OFF_MODE;
  wire wr_internal_addr_value = wr_in && addr_in == OFF_INT_ADDR;
  wire wr_cwg  = wr_in && addr_in == OFF_CLOCK_WAV;
  wire wr_ien  = wr_in && addr_in == OFF_INT_EN;
  wire wr_idis = wr_in && addr_in == OFF_INT_DIS;
  wire wr_thr  = wr_in && addr_in == OFF_TX_HOLD;
  wire rd_stat = rd_in && addr_in == OFF_STATUS;
  wire rd_rhr  = rd_in && addr_in == OFF_RX_HOLD;
  wire sw_rst  = wr_ctl && wdata_in[CTL_SWRST];
  wire msdis_cmd = wr_ctl && wdata_in[CTL_MSDIS];
  wire master_enable_cmd_cmd  = wr_ctl && wdata_in[CTL_MASTER_ENABLE_CMD] && !wdata_in[CTL_MSDIS];
  wire [FLG_W-1:0] ien_bits  = wr_ien ? wdata_in[FLG_W-1:0] & FLAG_USED
                                      : '0;
  wire [FLG_W-1:0] idis_bits = wr_idis ? wdata_in[FLG_W-1:0] & FLAG_USED
                                       : '0;

  wire [DATA_W-1:0] mode_word = (DATA_W'(target_device_address_q) << MODE_TARGET_DEVICE_ADDRESS_LSB)
                              | (DATA_W'(mode_rd_q) << MODE_READ_BIT)
                              | (DATA_W'(iasz_q) << MODE_IASZ_LSB);
  wire [DATA_W-1:0] cwg_word  = (DATA_W'(divisor_exponent_q) << CWG_EXP_LSB)
                              | (DATA_W'(high_phase_divisor_q) << CWG_HIGH_LSB)
                              | (DATA_W'(low_phase_divisor_q) << CWG_LOW_LSB);
  wire [DATA_W-1:0] rd_word =
      (addr_in == OFF_MODE)      ? mode_word :
      (addr_in == OFF_INT_ADDR)  ? DATA_W'(internal_addr_value_q) :
      (addr_in == OFF_CLOCK_WAV) ? cwg_word :
      (addr_in == OFF_STATUS)    ? DATA_W'(flags_q & FLAG_USED) :
      (addr_in == OFF_INT_MASK)  ? DATA_W'(imask_q) :
      (addr_in == OFF_RX_HOLD)   ? DATA_W'(rhr_q) :
      (addr_in == OFF_TX_HOLD)   ? DATA_W'(thr_q) : '0;

  // ======================================================================
  // Phase lengths and next-byte selection
  wire [CNT_W-1:0] low_len  = (CNT_W'(low_phase_divisor_q) << divisor_exponent_q)
                            + CNT_W'(PHASE_EXTRA);
  wire [CNT_W-1:0] high_len = (CNT_W'(high_phase_divisor_q) << divisor_exponent_q)
                            + CNT_W'(PHASE_EXTRA);
  wire [CNT_W-1:0] low_m1   = low_len - CNT_W'(1);
  wire [CNT_W-1:0] high_m1  = high_len - CNT_W'(1);

  // Internal address bytes go out most significant first, so the low byte
  // of the internal address register is always the last one.
  wire [1:0] idx_n = (stage_q == STG_DEV) ? fsz_q - 2'h1 : idx_q - 2'h1;
  wire [BYTE_W-1:0] internal_addr_value_byte = internal_addr_value_q[{idx_n, 3'h0} +: BYTE_W];

  always_comb begin
    case (stage_q)
      STG_DEV:  nxt = (fsz_q != 2'h0) ? N_INTERNAL_ADDR_VALUE : (frd_q ? N_RX : N_TX);
      STG_INTERNAL_ADDR_VALUE: nxt = (idx_q != 2'h0) ? N_INTERNAL_ADDR_VALUE : (frd_q ? N_RS : N_TX);
      STG_RDEV: nxt = N_RX;
      default:  nxt = frd_q ? N_RX : N_TX;
    endcase
  end

  wire no_ack_flag_bit = txm_q && sda_s_q;
  wire tx_empty = txm_q && !sda_s_q && nxt == N_TX && flags_q[FLG_TX_HOLDING_EMPTY];
  wire end_frame = no_ack_flag_bit || (!txm_q && last_q) || tx_empty;
  wire go = master_enable_cmd_q && scl_s_q && sda_s_q
         && (start_req_q || (!mode_rd_q && !flags_q[FLG_TX_HOLDING_EMPTY]));

  // ======================================================================
  // Pin drive: a low on the wire is a high output enable
  always_comb begin
    scl_want = state_q == ST_LO || state_q == ST_STOP_LO
            || state_q == ST_RS_LO;
    case (state_q)
      ST_START, ST_STOP_LO, ST_STOP_HI: sda_want = 1'b1;
      ST_LO, ST_HI: sda_want = (bit_q != ACK_BIT) ? txm_q && !sh_q[7]
                                                  : !txm_q && !last_q;
      default: sda_want = 1'b0;
    endcase
  end

  // SDA trails SCL by one cycle so that data never moves while the clock
  // edge is still settling on the wire.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {scl_m_q, scl_s_q, sda_m_q, sda_s_q} <= 4'hf;
      {scl_drv_q, sda_pre_q, sda_drv_q} <= 3'h0;
    end else begin
      {scl_m_q, scl_s_q} <= {scl_in, scl_m_q};
      {sda_m_q, sda_s_q} <= {sda_in, sda_m_q};
      scl_drv_q <= scl_want;
      sda_pre_q <= sda_want;
      sda_drv_q <= sda_pre_q;
    end
  end

  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  assign scl_oe_out = scl_drv_q;
  assign sda_oe_out = sda_drv_q;

  // ======================================================================
  // Bit and byte engine
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      stage_q <= STG_DEV;
      tmr_q <= '0;
      bit_q <= '0;
      sh_q <= '0;
      rhr_q <= '0;
      idx_q <= '0;
      fsz_q <= '0;
      {txm_q, last_q, no_ack_flag_pend_q, frd_q} <= 4'h0;
      {ev_begin_q, ev_done_q, ev_rx_q, ev_load_q} <= 4'h0;
      {ev_no_ack_flag_q, ev_underrun_flag_q, ev_stop_q} <= 3'h0;
    end else begin
      {ev_begin_q, ev_done_q, ev_rx_q, ev_load_q} <= 4'h0;
      {ev_no_ack_flag_q, ev_underrun_flag_q, ev_stop_q} <= 3'h0;
      if (sw_rst) begin
        state_q <= ST_IDLE;
        no_ack_flag_pend_q <= 1'b0;
        rhr_q <= '0;
      end else if (state_q != ST_IDLE && tmr_q != '0) begin
        tmr_q <= tmr_q - CNT_W'(1);
      end else begin
        case (state_q)
          ST_IDLE: if (go) begin
            state_q <= ST_START;
            tmr_q <= high_m1;
            stage_q <= STG_DEV;
            frd_q <= mode_rd_q;
            fsz_q <= iasz_q;
            sh_q <= {target_device_address_q, mode_rd_q && iasz_q == 2'h0};
            txm_q <= 1'b1;
            bit_q <= '0;
            ev_begin_q <= 1'b1;
          end
          ST_START, ST_LO: begin
            state_q <= (state_q == ST_LO) ? ST_HI : ST_LO;
            tmr_q <= (state_q == ST_LO) ? high_m1 : low_m1;
          end
          ST_HI: if (bit_q != ACK_BIT) begin
            sh_q <= {sh_q[6:0], sda_s_q};
            bit_q <= bit_q + 4'h1;
            state_q <= ST_LO;
            tmr_q <= low_m1;
            if (bit_q == LAST_BIT && !txm_q) begin
              rhr_q <= {sh_q[6:0], sda_s_q};
              ev_rx_q <= 1'b1;
              last_q <= stop_req_q;
            end
          end else if (end_frame) begin
            bit_q <= '0;
            state_q <= ST_STOP_LO;
            tmr_q <= low_m1;
            ev_stop_q <= 1'b1;
            no_ack_flag_pend_q <= no_ack_flag_bit;
            ev_underrun_flag_q <= tx_empty && !stop_req_q;
          end else begin
            bit_q <= '0;
            state_q <= (nxt == N_RS) ? ST_RS_LO : ST_LO;
            tmr_q <= low_m1;
            idx_q <= idx_n;
            txm_q <= nxt != N_RX;
            ev_load_q <= nxt == N_TX;
            stage_q <= (nxt == N_INTERNAL_ADDR_VALUE) ? STG_INTERNAL_ADDR_VALUE :
                       (nxt == N_RS) ? STG_RDEV : STG_DATA;
            sh_q <= (nxt == N_INTERNAL_ADDR_VALUE) ? internal_addr_value_byte :
                    (nxt == N_RS) ? {target_device_address_q, 1'b1} : thr_q;
          end
          ST_STOP_LO: begin
            state_q <= ST_STOP_HI;
            tmr_q <= high_m1;
          end
          ST_STOP_HI: begin
            state_q <= ST_STOP_END;
            tmr_q <= high_m1;
          end
          ST_STOP_END: begin
            state_q <= ST_IDLE;
            ev_done_q <= 1'b1;
            ev_no_ack_flag_q <= no_ack_flag_pend_q;
            no_ack_flag_pend_q <= 1'b0;
          end
          ST_RS_LO: begin
            state_q <= ST_RS_HI;
            tmr_q <= high_m1;
          end
          ST_RS_HI: begin
            state_q <= ST_START;
            tmr_q <= high_m1;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ======================================================================
  // Status flags: a set in the same cycle as a clear wins
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[FLG_TRANSFER_COMPLETE] = ev_done_q || master_enable_cmd_cmd;
    flag_clr[FLG_TRANSFER_COMPLETE] = ev_begin_q;
    flag_set[FLG_RX_BYTE_READY]  = ev_rx_q;
    flag_clr[FLG_RX_BYTE_READY]  = rd_rhr;
    flag_set[FLG_TX_HOLDING_EMPTY]  = ev_load_q || master_enable_cmd_cmd || ev_no_ack_flag_q;
    flag_clr[FLG_TX_HOLDING_EMPTY]  = wr_thr;
    flag_set[FLG_OVERRUN_FLAG]   = ev_rx_q && flags_q[FLG_RX_BYTE_READY];
    flag_clr[FLG_OVERRUN_FLAG]   = rd_stat && flags_q[FLG_TRANSFER_COMPLETE];
    flag_set[FLG_UNDERRUN_FLAG]   = ev_underrun_flag_q;
    flag_clr[FLG_UNDERRUN_FLAG]   = rd_stat && flags_q[FLG_TRANSFER_COMPLETE];
    flag_set[FLG_NO_ACK_FLAG]   = ev_no_ack_flag_q;
    flag_clr[FLG_NO_ACK_FLAG]   = rd_stat;
  end

  // ======================================================================
  // Software registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {target_device_address_q, mode_rd_q, iasz_q} <= '0;
      internal_addr_value_q <= '0;
      {low_phase_divisor_q, high_phase_divisor_q, divisor_exponent_q} <= '0;
      thr_q <= '0;
      imask_q <= '0;
      flags_q <= FLAG_RESET;
      {master_enable_cmd_q, start_req_q, stop_req_q} <= 3'h0;
    end else if (sw_rst) begin
      {target_device_address_q, mode_rd_q, iasz_q} <= '0;
      internal_addr_value_q <= '0;
      {low_phase_divisor_q, high_phase_divisor_q, divisor_exponent_q} <= '0;
      thr_q <= '0;
      imask_q <= '0;
      flags_q <= FLAG_RESET;
      {master_enable_cmd_q, start_req_q, stop_req_q} <= 3'h0;
    end else begin
      if (wr_mode) begin
        target_device_address_q <= wdata_in[MODE_TARGET_DEVICE_ADDRESS_LSB +: TARGET_DEVICE_ADDRESS_W];
        mode_rd_q <= wdata_in[MODE_READ_BIT];
        iasz_q <= wdata_in[MODE_IASZ_LSB +: 2];
      end
      if (wr_internal_addr_value) internal_addr_value_q <= wdata_in[INTERNAL_ADDR_VALUE_W-1:0];
      if (wr_cwg) begin
        low_phase_divisor_q <= wdata_in[CWG_LOW_LSB +: DIV_W];
        high_phase_divisor_q <= wdata_in[CWG_HIGH_LSB +: DIV_W];
        divisor_exponent_q <= wdata_in[CWG_EXP_LSB +: EXP_W];
      end
      if (wr_thr) thr_q <= wdata_in[BYTE_W-1:0];
      imask_q <= (imask_q | ien_bits) & ~idis_bits;
      if (msdis_cmd) master_enable_cmd_q <= 1'b0;
      else if (master_enable_cmd_cmd) master_enable_cmd_q <= 1'b1;
      start_req_q <= (start_req_q && !ev_begin_q)
                  || (wr_ctl && wdata_in[CTL_START] && state_q == ST_IDLE);
      stop_req_q <= (stop_req_q && !ev_stop_q)
                 || (wr_ctl && wdata_in[CTL_STOP]);
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= '0;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= rd_in ? rd_word : '0;
      irq_q <= |(flags_q & imask_q);
    end
  end

  assign rdata_out = rdata_q;
  assign irq_out   = irq_q;

  // ======================================================================
  // Checks
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lo_run_q <= '0;
      hi_run_q <= '0;
    end else begin
      lo_run_q <= (state_q == ST_LO) ? lo_run_q + CNT_W'(1) : '0;
      hi_run_q <= (state_q == ST_HI) ? hi_run_q + CNT_W'(1) : '0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_low_phase_len: assert property (
    $past(state_q) == ST_LO && state_q != ST_LO && !$past(wr_cwg)
    |-> lo_run_q == low_len) else $error("clock low phase length wrong");
  a_high_phase_len: assert property (
    $past(state_q) == ST_HI && state_q != ST_HI && !$past(wr_cwg)
    |-> hi_run_q == high_len) else $error("clock high phase length wrong");
  a_exp_scaling: assert property (
    $past(state_q) == ST_HI && state_q != ST_HI && !$past(wr_cwg)
    |-> (hi_run_q - CNT_W'(PHASE_EXTRA)) == (CNT_W'(high_phase_divisor_q) << divisor_exponent_q))
    else $error("exponent does not scale high phase");
  a_busy_no_done: assert property (
    state_q != ST_IDLE && $past(state_q, 2) != ST_IDLE
    && !$past(master_enable_cmd_cmd) |-> !flags_q[FLG_TRANSFER_COMPLETE])
    else $error("complete flag set inside a frame");
  a_rx_ready_set: assert property (
    ev_rx_q |=> flags_q[FLG_RX_BYTE_READY] && rhr_q == $past(rhr_q))
    else $error("receive-ready not set after byte");
  a_rhr_read_clr: assert property (
    rd_rhr && !ev_rx_q && !sw_rst |=> !flags_q[FLG_RX_BYTE_READY])
    else $error("receive holding read left ready set");
  a_overrun_set: assert property (
    ev_rx_q && flags_q[FLG_RX_BYTE_READY] && !sw_rst |=> flags_q[FLG_OVERRUN_FLAG])
    else $error("overrun not flagged");
  a_no_ack_flag_with_done: assert property (
    $rose(flags_q[FLG_NO_ACK_FLAG]) |-> flags_q[FLG_TRANSFER_COMPLETE] && flags_q[FLG_TX_HOLDING_EMPTY])
    else $error("no-ack flag without complete and empty");
  a_enable_bits: assert property (
    wr_ien && !wr_idis && !sw_rst
    |=> (imask_q & $past(ien_bits)) == $past(ien_bits))
    else $error("interrupt enable write lost");
  a_disable_bits: assert property (
    wr_idis && !sw_rst |=> (imask_q & $past(idis_bits)) == '0
    && (imask_q | $past(idis_bits)) == ($past(imask_q) | $past(idis_bits)))
    else $error("interrupt disable write wrong");
  a_addr_byte: assert property (
    ev_begin_q |-> sh_q[7:1] == target_device_address_q ##1 state_q == ST_START)
    else $error("slave address not loaded at frame start");
  a_irq_level: assert property (
    ##1 irq_q == |($past(flags_q) & $past(imask_q)))
    else $error("interrupt output does not follow flags");
endmodule : twm_master

// File: tb/twm_slave.sv
// Behavioural two-wire slave: acks, records every byte, serves reads.
`timescale 1ns/10ps
module twm_slave (
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       no_ack_flag_in,
  input  wire logic [7:0] byte_in,
  output logic            pull_out
);
  int         cnt = -2;
  logic       first, rdm, done;
  logic [7:0] sh;
  logic [7:0] seen_q[$];
  initial pull_out = 1'b0;
  always @(negedge sda_in) if (scl_in) begin
    cnt   = -1;
    first = 1'b1;
    done  = 1'b0;
  end
  always @(posedge sda_in) if (scl_in) cnt = -2;
  always @(posedge scl_in) if (cnt >= 0) begin
    if (cnt < 8) sh = {sh[6:0], sda_in};
    if (cnt == 8 && rdm && !first && sda_in) done = 1'b1;
  end
  // Data moves only while the clock is low; a master no-ack ends serving.
  always @(negedge scl_in) if (cnt > -2) begin
    if (cnt == 8) first = 1'b0;
    cnt = (cnt == 8) ? 0 : cnt + 1;
    if (cnt == 8) begin
      seen_q.push_back(sh);
      if (first) rdm = sh[0];
      pull_out = (first || !rdm) && !(no_ack_flag_in && !first);
    end else begin
      pull_out = rdm && !first && !done && !byte_in[7 - cnt];
    end
  end
endmodule : twm_slave

// File: tb/two_wire_master_regs_bench.sv
// Self-checking bench of the two-wire master against a slave model.
`timescale 1ns/10ps
module two_wire_master_regs_bench;
  import twm_pkg::*;
  logic              clk_in, reset_n_in, wr_in, rd_in, prev;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wdata_in, rdata_out, d;
  logic              scl_oe_out, sda_oe_out, irq_out, pull, no_ack_flag;
  logic              scl_out, sda_out;
  logic [7:0]        rbyte;
  logic [7:0]        q[$];
  wire               scl_w = ~scl_oe_out;
  wire               sda_w = ~(sda_oe_out | pull);
  int                n_fail, samples_checked, seed, m, e, x, lo, hi, ex;
  int                lo_len = 0, hi_len = 0, run = 0;
  twm_master u_dut (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .addr_in    (addr_in),
    .wdata_in   (wdata_in),
    .wr_in      (wr_in),
    .rd_in      (rd_in),
    .rdata_out  (rdata_out),
    .scl_in     (scl_w),
    .scl_out    (scl_out),
    .scl_oe_out (scl_oe_out),
    .sda_in     (sda_w),
    .sda_out    (sda_out),
    .sda_oe_out (sda_oe_out),
    .irq_out    (irq_out)
  );
  twm_slave u_slave (
    .scl_in   (scl_w),
    .sda_in   (sda_w),
    .no_ack_flag_in  (no_ack_flag),
    .byte_in  (rbyte),
    .pull_out (pull)
  );
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // =====
  // Phase lengths of the serial clock, counted in system clock cycles.
  initial prev = 1'b0;
  always @(posedge clk_in) begin
    if (scl_oe_out != prev) begin
      if (prev) lo_len <= run;
      else hi_len <= run;
      run <= 1;
    end else run <= run + 1;
    prev <= scl_oe_out;
  end
  // =====
  // Bus tasks and comparison.
  task automatic chk(input logic [31:0] s, input logic [31:0] t);
    samples_checked++;
    if (s !== t) begin
      n_fail++;
      $display("FAIL %0t seen %h exp %h", $time, s, t);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [31:0] t);
    rd(a, d);
    chk(d, t);
  endtask : rdchk
  task automatic setmode(input logic [6:0] a, input logic r,
                         input logic [1:0] s);
    wr(OFF_MODE, {9'h0, a, 3'h0, r, 2'h0, s, 8'h0});
    x = $random(seed);
    lo = x & 7;
    hi = (x >> 3) & 7;
    ex = (x >> 6) & 3;
    wr(OFF_CLOCK_WAV, {13'h0, ex[2:0], hi[7:0], lo[7:0]});
    u_slave.seen_q.delete();
  endtask : setmode
  // Waits for the completion interrupt to drop and come back.
  // The interrupt is looked at 1 ns after the edge, once it has settled.
  task automatic frame();
    for (int k = 0; k < 200 && irq_out === 1'b1; k++) begin
      @(posedge clk_in);
      #1;
    end
    chk(irq_out, 1'b0);
    rd(OFF_STATUS, d);
    chk(d[0], 1'b0);
    for (int k = 0; k < 20000 && irq_out !== 1'b1; k++) begin
      @(posedge clk_in);
      #1;
    end
    chk(irq_out, 1'b1);
    chk(lo_len, (lo << ex) + 3);
    chk(hi_len, (hi << ex) + 3);
  endtask : frame
  task automatic finish_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  initial begin
    #1_500_000;
    n_fail++;
    finish_test();
  end
  // =====
  // Main sequence.
  initial begin
    seed = 32'hb587;
    n_fail = 0;
    samples_checked = 0;
    {reset_n_in, wr_in, rd_in, addr_in, wdata_in, no_ack_flag, rbyte} = '0;
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rdchk(OFF_STATUS, 32'h5);
    rdchk(OFF_RX_HOLD, 32'h0);
    rdchk(8'h08, 32'h0);
    chk({scl_out, sda_out}, 32'h0);
    m = 0;
    for (int i = 0; i < 6; i++) begin
      e = $random(seed);
      x = $random(seed);
      wr(OFF_INT_EN, e);
      m = m | e;
      rdchk(OFF_INT_MASK, m & FLAG_USED);
      wr(OFF_INT_DIS, x);
      m = m & ~x;
      rdchk(OFF_INT_MASK, m & FLAG_USED);
      chk(irq_out, (m & 5) != 0);
    end
    wr(OFF_INT_DIS, 32'h1ff);
    wr(OFF_INT_EN, 32'h1);
    wr(OFF_CONTROL, 32'h4);
    for (int sz = 0; sz < 4; sz++) begin
      e = $random(seed);
      setmode(e[6:0], 1'b0, sz[1:0]);
      wr(OFF_INT_ADDR, e & 32'hffffff);
      wr(OFF_TX_HOLD, e[31:24]);
      rd(OFF_STATUS, d);
      chk(d[2], 1'b0);
      wr(OFF_CONTROL, 32'h3);
      frame();
      q = {};
      q.push_back({e[6:0], 1'b0});
      for (int k = sz - 1; k >= 0; k--) q.push_back(e[8 * k +: 8]);
      q.push_back(e[31:24]);
      chk(u_slave.seen_q.size(), q.size());
      foreach (q[i]) chk(u_slave.seen_q[i], q[i]);
      rdchk(OFF_STATUS, 32'h5);
    end
    no_ack_flag <= 1'b1;
    setmode(e[6:0], 1'b0, 2'h0);
    wr(OFF_TX_HOLD, 32'h5a);
    wr(OFF_CONTROL, 32'h3);
    frame();
    rdchk(OFF_STATUS, 32'h105);
    rdchk(OFF_STATUS, 32'h5);
    no_ack_flag <= 1'b0;
    setmode(e[6:0], 1'b0, 2'h0);
    wr(OFF_TX_HOLD, 32'ha5);
    frame();
    rdchk(OFF_STATUS, 32'h85);
    rdchk(OFF_STATUS, 32'h5);
    // The second read goes through one internal address byte and a
    // repeated start before the read address.
    for (int i = 0; i < 2; i++) begin
      rbyte <= $random(seed);
      setmode(e[6:0], 1'b1, i[1:0]);
      wr(OFF_CONTROL, 32'h3);
      frame();
      chk(u_slave.seen_q[0], {e[6:0], i == 0});
      chk(u_slave.seen_q[2 * i], {e[6:0], 1'b1});
      if (i) chk(u_slave.seen_q[1], e[7:0]);
      rdchk(OFF_STATUS, i ? 32'h47 : 32'h7);
    end
    rdchk(OFF_STATUS, 32'h7);
    rdchk(OFF_RX_HOLD, {24'h0, rbyte});
    rdchk(OFF_STATUS, 32'h5);
    finish_test();
  end
endmodule : two_wire_master_regs_bench
